// *** hw/svm_pkg.sv ***
package svm_pkg;
   // register map, byte addresses on the plain register port
   localparam int ADDR_W = 4;
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] REQ_ADDR = 4'h1;
   localparam logic [3:0] STAT_ADDR = 4'h2;
   localparam logic [3:0] MASK_ADDR = 4'h3;

   // supply_monitor_control fields
   localparam int THR_LSB = 0;
   localparam int THR_W = 3;
   localparam int BGOUT_BIT = 3;
   localparam int DETEN_BIT = 4;
   localparam int UVFLAG_BIT = 5;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // request register and event status / mask layout
   localparam int REQ_BIT = 0;
   localparam int EV_REQ_BIT = 0;
   localparam int EV_SETTLE_BIT = 1;
   localparam int EV_W = 2;
   localparam logic [1:0] EV_RESET = 2'h0;

   // trip levels in millivolts, indexed by threshold_select
   localparam int TRIP_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

   // timing
   localparam int CLK_MHZ = 200;
   localparam int SETTLE_TIME_NS = 100000;
   localparam int IRQ_DELAY_NS = 60000;
   localparam int CNT_W = 24;
endpackage

// *** hw/svm_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts cycles while run is high; done rises CYCLES edges after run rose
module svm_delay_timer #(
   parameter int CNT_W = 24,
   parameter int CYCLES = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic run,
   output logic done
);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   wire atEnd = (count_reg == LAST);

   // dropping run restarts the count from zero
   assign count_next = !run ? '0 : (atEnd ? count_reg : count_reg + CNT_W'(1));
   assign done = run && atEnd;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule
`default_nettype wire

// *** hw/svm_monitor.sv ***
// How it works
// - threshold_select bits 2..0 pick one of eight ascending trip levels, 2.0V to 4.0V.
// - read-only bit 5 shows one while supply is below the selected level.
// - detector_enable bit 4 turns the detector on; zero switches it off.
// - bit 3 is a read-write enable for the bandgap reference output.
// - bandgap runs when detector enable, brownout reset or bandgap output enable is on, in SLEEP too.
// - bits 7 and 6 read zero and ignore writes.
// - in SLEEP the detector stays off even with its enable set.
// - the undervoltage flag follows the comparator with no hysteresis.
// - the interrupt request feeds a grouped interrupt as alternative to polling.
// - hardware sets the request only after the irq delay of continuous undervoltage; a software write of one sets it at once.
// - a rising request flag wakes the core from IDLE.
// - any low-to-high request change while in IDLE wakes, regardless of interrupt enables.
// - servicing clears only the group flag; software clears the request flag.
`timescale 1ns/1ps
`default_nettype none
module svm_monitor
   import svm_pkg::*;
#(
   parameter int SETTLE_NS = SETTLE_TIME_NS,
   parameter int IRQ_NS = IRQ_DELAY_NS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // analog and power-mode side
   input wire logic cmpResult,
   input wire logic brownoutEnable,
   input wire logic sleepMode,
   input wire logic idleMode,
   output logic detectorOn,
   output logic bandgapOn,
   output logic bandgapOutEnable,
   output logic [THR_W-1:0] thresholdSelect,
   // interrupt controller side
   input wire logic groupServiced,
   output logic undervoltageIrqRequest,
   output logic groupIrqRequest,
   output logic wakeup,
   output logic irq
);
   // least times round up to whole cycles
   localparam int SETTLE_CYC_RAW = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int IRQ_CYC_RAW = (IRQ_NS * CLK_MHZ + 999) / 1000;
   localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int IRQ_CYC = (IRQ_CYC_RAW < 1) ? 1 : IRQ_CYC_RAW;

   logic [4:0] ctrl_reg;
   logic [4:0] ctrl_next;
   logic cmpMeta_reg;
   logic cmpSync_reg;
   logic req_reg;
   logic req_next;
   logic reqPrev_reg;
   logic group_reg;
   logic group_next;
   logic wake_reg;
   logic settlePrev_reg;
   logic [EV_W-1:0] stat_reg;
   logic [EV_W-1:0] stat_next;
   logic [EV_W-1:0] mask_reg;
   logic [7:0] rd_reg;
   logic [7:0] rdMux;
   logic settleDone;
   logic irqDelayDone;
   logic irqDelayPrev_reg;

   // address decode
   wire selCtrl = (regAddr == CTRL_ADDR);
   wire selReq = (regAddr == REQ_ADDR);
   wire selStat = (regAddr == STAT_ADDR);
   wire selMask = (regAddr == MASK_ADDR);
   wire wrCtrl = regWrite && selCtrl;
   wire wrReq = regWrite && selReq;
   wire wrStat = regWrite && selStat;
   wire wrMask = regWrite && selMask;

   wire detEnBit = ctrl_reg[DETEN_BIT];
   wire detectorActive = detEnBit && !sleepMode;
   wire uvFlag = detectorActive && cmpSync_reg;
   wire hwSet = irqDelayDone && !irqDelayPrev_reg;
   wire reqRise = req_reg && !reqPrev_reg;
   wire settleRise = settleDone && !settlePrev_reg;
   wire [EV_W-1:0] events = {settleRise, reqRise};
   wire [EV_W-1:0] w1c = wrStat ? regWrData[EV_W-1:0] : EV_RESET;

   // only bits 4..0 are storage; bits 7..6 writes dropped
   assign ctrl_next = wrCtrl ? regWrData[4:0] : ctrl_reg;
   // hardware set wins over a software clear in the same cycle
   assign req_next = hwSet || (wrReq ? regWrData[REQ_BIT] : req_reg);
   assign group_next = reqRise || (group_reg && !groupServiced);
   assign stat_next = (stat_reg & ~w1c) | events;

   assign rdMux = selCtrl ? {2'h0, uvFlag, ctrl_reg} :
                  selReq ? {7'h00, req_reg} :
                  selStat ? {6'h00, stat_reg} :
                  selMask ? {6'h00, mask_reg} : 8'h00;

   assign regRdData = rd_reg;
   assign detectorOn = detectorActive;
   assign bandgapOutEnable = ctrl_reg[BGOUT_BIT];
   assign bandgapOn = detEnBit || brownoutEnable || ctrl_reg[BGOUT_BIT];
   assign thresholdSelect = ctrl_reg[THR_LSB +: THR_W];
   assign undervoltageIrqRequest = req_reg;
   assign groupIrqRequest = group_reg;
   assign wakeup = wake_reg;
   assign irq = |(stat_reg & mask_reg);

   // settle window after enabling, reported as an event
   svm_delay_timer #(
      .CNT_W(CNT_W),
      .CYCLES(SETTLE_CYC)
   ) settleTimer (
      .ref_clk(ref_clk),
      .rst(rst),
      .run(detectorActive),
      .done(settleDone)
   );

   // low flag restarts the delay count
   svm_delay_timer #(
      .CNT_W(CNT_W),
      .CYCLES(IRQ_CYC)
   ) irqTimer (
      .ref_clk(ref_clk),
      .rst(rst),
      .run(uvFlag),
      .done(irqDelayDone)
   );

   // comparator synchroniser
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmpMeta_reg <= 1'b0;
         cmpSync_reg <= 1'b0;
      end else begin
         cmpMeta_reg <= cmpResult;
         cmpSync_reg <= cmpMeta_reg;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET[4:0];
         mask_reg <= EV_RESET;
         stat_reg <= EV_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
         stat_reg <= stat_next;
         if (wrMask) begin
            mask_reg <= regWrData[EV_W-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         req_reg <= 1'b0;
         reqPrev_reg <= 1'b0;
         group_reg <= 1'b0;
         wake_reg <= 1'b0;
         settlePrev_reg <= 1'b0;
         irqDelayPrev_reg <= 1'b0;
      end else begin
         req_reg <= req_next;
         reqPrev_reg <= req_reg;
         group_reg <= group_next;
         wake_reg <= reqRise && idleMode;
         settlePrev_reg <= settleDone;
         irqDelayPrev_reg <= irqDelayDone;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_reg <= 8'h00;
      end else begin
         rd_reg <= regRead ? rdMux : 8'h00;
      end
   end

   // helper: cycles the flag has been high without a break
   logic [CNT_W-1:0] uvHigh_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         uvHigh_reg <= '0;
      end else begin
         uvHigh_reg <= uvFlag ? uvHigh_reg + CNT_W'(1) : '0;
      end
   end

   sync_path_a: assert property (@(posedge ref_clk) disable iff (rst)
      $past(cmpResult, 2) && $past(detectorActive) && detectorActive |-> uvFlag)
      else $error("comparator did not reach flag after two stages");

   sleep_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      sleepMode |-> !detectorOn && !uvFlag)
      else $error("detector active in sleep");

   det_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
      wrCtrl ##1 !sleepMode |-> detectorOn == $past(regWrData[DETEN_BIT]))
      else $error("detector enable not applied");

   thr_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      wrCtrl |=> thresholdSelect == $past(regWrData[2:0]) && bandgapOutEnable == $past(regWrData[3]))
      else $error("threshold or bandgap bit not stored");

   bandgap_on_a: assert property (@(posedge ref_clk) disable iff (rst)
      (detEnBit || brownoutEnable || bandgapOutEnable) == bandgapOn)
      else $error("bandgap enable wrong");

   rsvd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      regRead && selCtrl |=> regRdData[7:6] == 2'h0 && regRdData[5] == $past(uvFlag))
      else $error("control read wrong in bits 7..5");

   irq_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      hwSet |-> uvHigh_reg >= CNT_W'(IRQ_CYC))
      else $error("request set before the delay ran out");

   wake_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !req_reg ##1 req_reg && idleMode |=> wakeup)
      else $error("no wake-up on rising request");

   group_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      groupServiced && req_reg && !wrReq |=> req_reg && !(groupIrqRequest && !$past(reqRise)))
      else $error("service touched request or kept group flag");

   read_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !regRead |=> regRdData == 8'h00)
      else $error("read data outside the answer cycle");

   group_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      reqRise |=> groupIrqRequest)
      else $error("group request not raised");

   req_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      req_reg && !wrReq |=> req_reg)
      else $error("request dropped without a software clear");

   flag_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      regRead && selCtrl && !detectorActive |=> !regRdData[UVFLAG_BIT])
      else $error("flag shown while detector off");

   wake_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      wakeup |=> !wakeup)
      else $error("wake-up longer than one cycle");

   wake_idle_only_a: assert property (@(posedge ref_clk) disable iff (rst)
      !idleMode |=> !wakeup)
      else $error("wake-up outside idle");

   stat_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      reqRise |=> stat_reg[EV_REQ_BIT])
      else $error("request event not recorded");

   stat_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
      stat_reg[EV_REQ_BIT] && !(wrStat && regWrData[EV_REQ_BIT]) |=> stat_reg[EV_REQ_BIT])
      else $error("status bit lost without a clear");

   irq_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
      !uvFlag |=> !irqDelayDone)
      else $error("irq delay not restarted by low flag");

   ctrl_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !wrCtrl |=> $stable(ctrl_reg))
      else $error("control changed without a write");
endmodule
`default_nettype wire

// *** test/tb_svm_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_svm_monitor
   import svm_pkg::*;
;
   localparam int IRQ_CYC = 10;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic cmpResult = 1'b0;
   logic brownoutEnable = 1'b0;
   logic sleepMode = 1'b0;
   logic idleMode = 1'b0;
   logic groupServiced = 1'b0;
   logic [7:0] regRdData;
   logic detectorOn, bandgapOn, bandgapOutEnable, uvReq, groupReq, wakeup, irq;
   logic [THR_W-1:0] thresholdSelect;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int nWake = 0;
   int waitCnt;

   svm_monitor #(.SETTLE_NS(50), .IRQ_NS(50)) dut (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .cmpResult(cmpResult), .brownoutEnable(brownoutEnable), .sleepMode(sleepMode),
      .idleMode(idleMode), .detectorOn(detectorOn), .bandgapOn(bandgapOn),
      .bandgapOutEnable(bandgapOutEnable), .thresholdSelect(thresholdSelect),
      .groupServiced(groupServiced), .undervoltageIrqRequest(uvReq),
      .groupIrqRequest(groupReq), .wakeup(wakeup), .irq(irq)
   );

   always #2.5 ref_clk = ~ref_clk;

   task automatic stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // cycle ceiling well above the expected run length
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (wakeup === 1'b1) nWake <= nWake + 1;
      if (cycles == 3000) begin
         failures = failures + 1;
         stop_test();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 chk(name, exp, regRdData);
   endtask

   initial begin
      tick(20);
      rst <= 1'b0;
      rd(CTRL_ADDR, CTRL_RESET, "ctrl reset");
      rd(STAT_ADDR, {6'h00, EV_RESET}, "status reset");
      rd(REQ_ADDR, 8'h00, "request reset");
      wr(CTRL_ADDR, 8'hFF);
      rd(CTRL_ADDR, 8'h1F, "ctrl upper bits");
      for (int t = 0; t < 8; t++) begin
         wr(CTRL_ADDR, 8'h08 | t[7:0]);
         chk("thresholdSelect", t[7:0], {5'h00, thresholdSelect});
         rd(CTRL_ADDR, 8'h08 | t[7:0], "ctrl threshold");
      end
      for (int k = 0; k < 8; k++) begin
         @(posedge ref_clk) brownoutEnable <= k[2];
         wr(CTRL_ADDR, {3'h0, k[1], k[0], 3'h2});
         chk("bandgapOn", |k[2:0], bandgapOn);
         chk("bandgapOutEnable", k[0], bandgapOutEnable);
         chk("detectorOn", k[1], detectorOn);
      end
      @(posedge ref_clk) sleepMode <= 1'b1;
      @(posedge ref_clk);
      #1 chk("detectorOn in sleep", 1'b0, detectorOn);
      @(posedge ref_clk) sleepMode <= 1'b0;
      tick(20);
      rd(STAT_ADDR, 8'h02, "settle event");
      wr(STAT_ADDR, 8'h02);
      rd(STAT_ADDR, 8'h00, "settle cleared");
      wr(MASK_ADDR, 8'h01);
      rd(MASK_ADDR, 8'h01, "mask readback");
      @(posedge ref_clk) idleMode <= 1'b1;
      // short low-supply episodes must not reach the request
      for (int g = 0; g < 3; g++) begin
         @(posedge ref_clk) cmpResult <= 1'b1;
         tick(2);
         rd(CTRL_ADDR, 8'h3A, "flag high");
         @(posedge ref_clk) cmpResult <= 1'b0;
         tick(2);
         rd(CTRL_ADDR, 8'h1A, "flag low");
      end
      chk("request after glitches", 1'b0, uvReq);
      @(posedge ref_clk) cmpResult <= 1'b1;
      waitCnt = 0;
      while (uvReq !== 1'b1 && waitCnt < 40) begin
         @(posedge ref_clk);
         #1 waitCnt++;
      end
      chk("irq delay cycles", 8'(IRQ_CYC + 3), waitCnt[7:0]);
      tick(2);
      #1 chk("groupIrqRequest", 1'b1, groupReq);
      chk("irq", 1'b1, irq);
      chk("wakeup count", 8'h01, nWake[7:0]);
      wr(MASK_ADDR, 8'h00);
      chk("irq masked", 1'b0, irq);
      wr(MASK_ADDR, 8'h01);
      chk("irq unmasked", 1'b1, irq);
      @(posedge ref_clk) groupServiced <= 1'b1;
      @(posedge ref_clk) groupServiced <= 1'b0;
      #1 chk("group after service", 1'b0, groupReq);
      chk("request after service", 1'b1, uvReq);
      wr(STAT_ADDR, 8'h01);
      chk("irq after clear", 1'b0, irq);
      wr(REQ_ADDR, 8'h00);
      rd(REQ_ADDR, 8'h00, "request cleared");
      @(posedge ref_clk) idleMode <= 1'b0;
      wr(REQ_ADDR, 8'h01);
      @(posedge ref_clk) idleMode <= 1'b1;
      @(posedge ref_clk) cmpResult <= 1'b0;
      tick(3);
      @(posedge ref_clk) cmpResult <= 1'b1;
      tick(IRQ_CYC + 8);
      #1 chk("wakeup with request preset", 8'h01, nWake[7:0]);
      rd(STAT_ADDR, 8'h01, "status software set");
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00, "unmapped read");
      stop_test();
   end
endmodule
`default_nettype wire
